// file: logic/ecp_defs.svh
// Notes on behaviour
// - shutdown status flag at shutdown register bit 7
// - auto restart ends pulse at once on shutdown
// - auto restart resumes pulse mid-period when clear
// - manual restart waits for software status clear
// - mode 1011 resets timer on compare match
// - match reset ignores prescaler rollover
// - prescale 1/2/4/8 from two-bit select
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_SHUT 8'h04
`define ADDR_DELAY 8'h08
`define ADDR_CMP 8'h0C
`define ADDR_TIMER 8'h10
`define ADDR_DUTY 8'h14
`define ADDR_PERIOD 8'h18
`define ADDR_STATUS 8'h1C
`define ADDR_MASK 8'h20
`define BIT_FLAG 7
`define BIT_RESTART 7
`define MODE_SPECIAL 4'hB
`define MODE_PWM 4'hC
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define EV_SHUT 0
`define EV_MATCH 1
`endif

// file: logic/ecp_pkg.sv
package ecp_pkg;
  typedef struct packed {
    logic [1:0] pin_a_state;
    logic [1:0] pin_b_state;
    logic [1:0] src_enable;
  } shut_cfg_t;
  typedef struct packed {
    logic a;
    logic b;
  } pwm_out_t;
  typedef enum logic [1:0] {WAIT_ADDR, WAIT_RESP} wr_state_t;
endpackage : ecp_pkg

// file: logic/ecp_unit.sv
`timescale 1ns/1ps
`include "ecp_defs.svh"
module ecp_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // shutdown sources and count pin
  input wire logic [1:0] shutdown_in,
  input wire logic count_pin,
  // outputs
  output ecp_pkg::pwm_out_t pwm_out,
  output logic special_trigger,
  output logic irq
);
  import ecp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields and internal state
  logic [3:0] compare_pwm_mode_field;
  logic [1:0] timer_prescale_select;
  logic timer_use_pin;
  logic timer_on;
  shut_cfg_t shut_cfg;
  logic shutdown_status_flag;
  logic auto_restart_enable;
  logic [15:0] compare_value;
  logic [15:0] timer_count;
  logic [15:0] duty_reg;
  logic [15:0] period_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [1:0] sd_s1, sd_s2;
  logic cp_s1, cp_s2, cp_s3;
  logic aw_held, w_held;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic match;
  logic tick;
  logic shut_active;
  logic sw_clear_flag;
  logic [1:0] ev_set;
  logic [1:0] w1c;
  logic pwm_level;
  logic count_event;
  logic pwm_mode;

  // byte-lane merge used by every writable register except the delay and status registers
  // lanes without a strobe keep their old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // pins are asynchronous: two flops before use
  // the count pin has a third flop so its rising edge can be found
  always_ff @(posedge clk) begin
    if (rst) begin
      sd_s1 <= 2'h0;
      sd_s2 <= 2'h0;
      cp_s1 <= 1'b0;
      cp_s2 <= 1'b0;
      cp_s3 <= 1'b0;
    end else begin
      sd_s1 <= shutdown_in;
      sd_s2 <= sd_s1;
      cp_s1 <= count_pin;
      cp_s2 <= cp_s1;
      cp_s3 <= cp_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order, response after both
  // readies pulse for one cycle; the held flags stop a second take
  // the !bvalid term in wr_fire keeps the held write from firing again under the response
  assign wr_fire = aw_held && w_held && !bvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      awready <= !aw_held && !awready && awvalid;
      wready <= !w_held && !wready && wvalid;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        case (aw_addr_reg)
          `ADDR_CTRL, `ADDR_SHUT, `ADDR_DELAY, `ADDR_CMP, `ADDR_TIMER,
          `ADDR_DUTY, `ADDR_PERIOD, `ADDR_STATUS, `ADDR_MASK: bresp <= `RESP_OKAY;
          default: bresp <= `RESP_SLVERR;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  // unmapped offsets hit the default arm and change nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_pwm_mode_field <= 4'h0;
      timer_prescale_select <= 2'h0;
      timer_use_pin <= 1'b0;
      timer_on <= 1'b0;
      shut_cfg <= '0;
      auto_restart_enable <= 1'b0;
      compare_value <= 16'hFFFF;
      duty_reg <= 16'h0000;
      period_reg <= 16'h00FF;
      mask_reg <= 2'h0;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        `ADDR_CTRL: begin
          {timer_on, timer_use_pin, timer_prescale_select, compare_pwm_mode_field} <=
            8'(merge({24'h0, timer_on, timer_use_pin, timer_prescale_select, compare_pwm_mode_field},
                  w_data_reg, w_strb_reg));
        end
        `ADDR_SHUT: shut_cfg <= 6'(merge({26'h0, shut_cfg}, w_data_reg, w_strb_reg));
        `ADDR_DELAY: begin
          if (w_strb_reg[0]) begin
            auto_restart_enable <= w_data_reg[`BIT_RESTART];
          end
        end
        `ADDR_CMP: compare_value <= 16'(merge({16'h0, compare_value}, w_data_reg, w_strb_reg));
        `ADDR_DUTY: duty_reg <= 16'(merge({16'h0, duty_reg}, w_data_reg, w_strb_reg));
        `ADDR_PERIOD: period_reg <= 16'(merge({16'h0, period_reg}, w_data_reg, w_strb_reg));
        `ADDR_MASK: mask_reg <= 2'(merge({30'h0, mask_reg}, w_data_reg, w_strb_reg));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer with prescaler; counts clocks or rising edges of the count pin
  // the prescaler steps only on count events, so in pin mode it divides pin edges
  prescaler u_pre (
    .clk(clk),
    .rst(rst),
    .sel(timer_prescale_select),
    .clear(match),
    .step(count_event),
    .tick(tick)
  );
  assign match = (compare_pwm_mode_field == `MODE_SPECIAL) && (timer_count == compare_value);
  assign count_event = timer_on && (timer_use_pin ? (cp_s2 && !cp_s3) : 1'b1);
  assign pwm_mode = (compare_pwm_mode_field == `MODE_PWM);
  // a software write beats the match, and the match beats a period wrap or a count
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_count <= 16'h0000;
    end else if (wr_fire && aw_addr_reg == `ADDR_TIMER) begin
      timer_count <= 16'(merge({16'h0, timer_count}, w_data_reg, w_strb_reg));
    end else if (match) begin
      timer_count <= 16'h0000; // reset at the match itself, not at rollover
    end else if (pwm_mode && timer_count >= period_reg && count_event && tick) begin
      timer_count <= 16'h0000;
    end else if (count_event && tick) begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  // one-cycle strobe, one clock after the match
  always_ff @(posedge clk) begin
    if (rst) begin
      special_trigger <= 1'b0;
    end else begin
      special_trigger <= match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown flag; hardware set wins over the software clear
  // the set follows the level, so the flag stays up while a source is active
  // a one written to the flag bit does nothing; only a zero clears it
  assign shut_active = |(sd_s2 & shut_cfg.src_enable);
  assign sw_clear_flag = wr_fire && aw_addr_reg == `ADDR_SHUT && w_strb_reg[0] && !w_data_reg[`BIT_FLAG];
  always_ff @(posedge clk) begin
    if (rst) begin
      shutdown_status_flag <= 1'b0;
    end else if (shut_active) begin
      shutdown_status_flag <= 1'b1;
    end else if (auto_restart_enable) begin
      shutdown_status_flag <= 1'b0; // resumes mid-period, short pulses possible
    end else if (sw_clear_flag) begin
      shutdown_status_flag <= 1'b0; // only once the condition has gone
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm output stage; flag forces configured states at once
  // shut_active is looked at too, so the pulse ends in the cycle the flag is set
  // outside pwm mode both outputs rest low
  assign pwm_level = pwm_mode && (timer_count < duty_reg);
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_out <= '0;
    end else if (shutdown_status_flag || shut_active) begin
      pwm_out.a <= shut_cfg.pin_a_state[0];
      pwm_out.b <= shut_cfg.pin_b_state[0];
    end else begin
      pwm_out.a <= pwm_level;
      pwm_out.b <= !pwm_level && pwm_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, set beats clear
  // irq is built from the next status so it rises together with the status bit
  assign ev_set = {match, shut_active && !shutdown_status_flag};
  assign w1c = (wr_fire && aw_addr_reg == `ADDR_STATUS && w_strb_reg[0]) ? w_data_reg[1:0] : 2'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~w1c) | ev_set;
      irq <= |(((status_reg & ~w1c) | ev_set) & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: answer one cycle after address taken; flag readable at bit 7
  // read data is captured at the address handshake and held until taken
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid && arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case (araddr)
          `ADDR_CTRL: rdata <= {24'h0, timer_on, timer_use_pin, timer_prescale_select, compare_pwm_mode_field};
          `ADDR_SHUT: rdata <= {24'h0, shutdown_status_flag, 1'b0, shut_cfg};
          `ADDR_DELAY: rdata <= {24'h0, auto_restart_enable, 7'h00};
          `ADDR_CMP: rdata <= {16'h0, compare_value};
          `ADDR_TIMER: rdata <= {16'h0, timer_count};
          `ADDR_DUTY: rdata <= {16'h0, duty_reg};
          `ADDR_PERIOD: rdata <= {16'h0, period_reg};
          `ADDR_STATUS: rdata <= {30'h0, status_reg};
          `ADDR_MASK: rdata <= {30'h0, mask_reg};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : ecp_unit

// file: logic/prescaler.sv
`timescale 1ns/1ps
`include "ecp_defs.svh"
module prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [1:0] sel,
  input wire logic clear,
  input wire logic step,
  // tick out
  output logic tick
);
  logic [2:0] cnt_reg;
  logic [2:0] limit;
  // divide by 1, 2, 4 or 8
  always_comb begin
    limit = 3'((4'h1 << sel) - 4'h1);
  end
  // only count events advance the division, so a stopped timer keeps its phase
  assign tick = step && (cnt_reg == limit);
  // clear restarts the division so a match reset leaves no partial tick
  always_ff @(posedge clk) begin
    if (rst || clear || tick) begin
      cnt_reg <= 3'h0;
    end else if (step) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
endmodule : prescaler

// file: sim/ecp_unit_sva.sv
`timescale 1ns/1ps
module ecp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // outputs
  input wire logic special_trigger,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // named steps of a bus transfer
  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  sequence s_b_taken;
    bvalid && bready;
  endsequence
  property p_ar_ans; s_ar_taken |=> rvalid; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  property p_r_done; rvalid && rready |=> !rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_b_done; s_b_taken |=> !bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_aw_one; awready |=> !awready; endproperty
  a_aw_one: assert property (p_aw_one) else $error("awready held");
  property p_w_one; wready |=> !wready; endproperty
  a_w_one: assert property (p_w_one) else $error("wready held");
  property p_resp; bvalid |-> bresp == 2'h0 || bresp == 2'h2; endproperty
  a_resp: assert property (p_resp) else $error("bad write response");
  property p_trig; special_trigger |=> !special_trigger; endproperty
  a_trig: assert property (p_trig) else $error("trigger not a pulse");
  // reset must be seen here, so the default disable is overridden
  property p_rst; disable iff (1'b0) rst |=> !irq && !special_trigger && !bvalid; endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
endmodule : ecp_chk

bind ecp_unit ecp_chk u_chk (.clk(clk), .rst(rst), .awready(awready), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .special_trigger(special_trigger), .irq(irq));

// file: sim/shut_src_model.sv
`timescale 1ns/1ps
module shut_src_model (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic [1:0] shut_req,
  input wire logic count_en,
  // pins toward the unit
  output logic [1:0] shutdown_in,
  output logic count_pin
);
  // fault sources follow the bench; dropping a request expires the condition
  always_ff @(posedge clk) shutdown_in <= shut_req;
  // count pin stands low outside a count burst, else a rising edge every two cycles
  always_ff @(posedge clk) count_pin <= count_en ? ~count_pin : 1'b0;
endmodule : shut_src_model

// file: sim/tb_enhanced_compare_pwm_shutdown.sv
`timescale 1ns/1ps
`include "ecp_defs.svh"
module tb_enhanced_compare_pwm_shutdown;
  import ecp_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, count_en;
  logic awready, wready, bvalid, arready, rvalid, count_pin, special_trigger, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r2, shutdown_in, shut_req;
  pwm_out_t pwm_out;
  int n_fail, checks, g;
  ecp_unit uut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .shutdown_in(shutdown_in),
    .count_pin(count_pin), .pwm_out(pwm_out), .special_trigger(special_trigger), .irq(irq));
  shut_src_model partner (.clk(clk), .shut_req(shut_req), .count_en(count_en),
    .shutdown_in(shutdown_in), .count_pin(count_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // bus tasks; each starts one edge on so no strobe is set twice at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // no wait limit in the bus tasks: a hung bus is caught by the watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r2 = bresp; bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata; r2 = rresp; rready <= 1'b0;
  endtask : rd
  // skip to one trigger, then count cycles to the next
  task automatic gap;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!special_trigger && n < 2000);
    g = 0;
    do begin @(posedge clk); g++; end while (!special_trigger && g < 2000);
  endtask : gap
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // a hang counts against the run
  initial begin
    // about twenty thousand cycles, many times what the tests need
    #200000;
    n_fail++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF; shut_req = 2'h0; count_en = 1'b0;
    n_fail = 0; checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_CMP); chk(v, 32'h0000FFFF);
    rd(`ADDR_PERIOD); chk(v, 32'h000000FF);
    rd(8'h24); chk(v, 32'h0); chk(32'(r2), 32'(`RESP_SLVERR));
    wr(8'h24, 32'h0); chk(32'(r2), 32'(`RESP_SLVERR));
    // match period is compare times the divide, plus the cycle that holds the match
    wr(`ADDR_MASK, 32'h2); chk(32'(r2), 32'(`RESP_OKAY));
    wr(`ADDR_CMP, 32'h5);
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_CTRL, 32'h80 | (s << 4) | `MODE_SPECIAL);
      gap(); chk(32'(g), 32'((5 << s) + 1));
    end
    chk(32'(irq), 32'h1);
    wr(`ADDR_CTRL, 32'h0);
    rd(`ADDR_STATUS); chk(v, 32'h2);
    wr(`ADDR_STATUS, 32'h2); chk(32'(irq), 32'h0);
    // counting pin edges through a divide by two
    // edges come every two cycles and the match falls between edges, so no extra cycle
    count_en <= 1'b1;
    wr(`ADDR_CTRL, 32'hD0 | `MODE_SPECIAL);
    gap(); chk(32'(g), 32'd20);
    wr(`ADDR_CTRL, 32'h0);
    count_en <= 1'b0;
    // software restart: outputs stay forced until the flag is written low
    wr(`ADDR_PERIOD, 32'h0F); wr(`ADDR_DUTY, 32'h8);
    wr(`ADDR_CTRL, 32'h80 | `MODE_PWM); wr(`ADDR_SHUT, 32'h11);
    shut_req <= 2'b01;
    repeat (6) @(posedge clk);
    chk(32'(pwm_out), 32'h2);
    rd(`ADDR_SHUT); chk(32'(v[7]), 32'h1);
    shut_req <= 2'b00;
    repeat (20) @(posedge clk);
    chk(32'(pwm_out), 32'h2);
    wr(`ADDR_SHUT, 32'h11);
    rd(`ADDR_SHUT); chk(v, 32'h11);
    rd(`ADDR_STATUS); chk(32'(v[0]), 32'h1);
    // automatic restart ends the pulse, then lets go by itself
    wr(`ADDR_DELAY, 32'h80);
    shut_req <= 2'b01;
    repeat (6) @(posedge clk);
    chk(32'(pwm_out), 32'h2);
    shut_req <= 2'b00;
    repeat (10) @(posedge clk);
    rd(`ADDR_SHUT); chk(32'(v[7]), 32'h0);
    // shutdown event through the mask
    // irq follows a mask write one cycle after the write response
    wr(`ADDR_MASK, 32'h1);
    @(posedge clk); chk(32'(irq), 32'h1);
    wr(`ADDR_MASK, 32'h0);
    @(posedge clk); chk(32'(irq), 32'h0);
    results();
  end
endmodule : tb_enhanced_compare_pwm_shutdown
